// *** logic/module_sideband_control_pins.sv ***
// sideband control and status pin logic of a pluggable optical module
//
// Overview of operation
// - while select is low, pass two-wire bus traffic to the management core
// - while select is high, never acknowledge nor drive the data line
// - an undriven select input reads as deselected through an internal pull-up
// - an undriven reset input reads inactive high through an internal pull-up
// - a long enough reset low restores all user settings to defaults
// - the initialisation interval starts when the reset input rises
// - at reset end clear data-not-ready and assert the interrupt
// - after power-up raise the same completion interrupt without a reset
// - low-power request high puts the module into its low-power state
// - presence output is low while the module is seated
// - interrupt pulled low on a fault or critical status condition
// - interrupt is only pulled low or released, never driven high
// - module is fully functional within 2000 ms of supply good
// - latched flags sit in the lower page and drive the interrupt
`timescale 1ns/10ps
module module_sideband_control_pins
#(
  parameter int unsigned POWER_UP_CYCLES  = sideband_pkg::POWER_UP_CYC,
  parameter int unsigned INIT_CYCLES      = sideband_pkg::INIT_CYC,
  parameter int unsigned MIN_PULSE_CYCLES = sideband_pkg::MIN_RESET_CYC
)
(
  input  wire logic i_clk,
  input  wire logic i_reset,
  input  wire logic i_module_select_n,
  input  wire logic i_module_select_hiz,
  input  wire logic i_module_reset_n,
  input  wire logic i_module_reset_hiz,
  input  wire logic i_low_power_request,
  input  wire logic i_scl,
  input  wire logic i_sda,
  input  wire logic i_core_sda_pull,
  input  wire logic i_flag_pending,
  input  wire logic i_flags_read,
  output logic      o_sda_out,
  output logic      o_sda_oe_n,
  output logic      o_core_scl,
  output logic      o_core_sda,
  output logic      o_present_n,
  output logic      o_interrupt_n_out,
  output logic      o_interrupt_n_oe_n,
  output logic      o_low_power,
  output logic      o_settings_reset,
  output logic      o_core_hold,
  output logic      o_data_not_ready
);
  import sideband_pkg::*;

  localparam logic [CNT_W-1:0] PWR_LOAD  = CNT_W'(POWER_UP_CYCLES - 1);
  localparam logic [CNT_W-1:0] INIT_LOAD = CNT_W'(INIT_CYCLES - 1);
  localparam logic [CNT_W-1:0] MIN_LAST  = CNT_W'(MIN_PULSE_CYCLES - 1);

  pins_t raw;
  pins_t pin_s;

  always_comb
  begin
    raw.select_n  = i_module_select_n | i_module_select_hiz;
    raw.reset_n   = i_module_reset_n | i_module_reset_hiz;
    raw.low_power = i_low_power_request;
    raw.scl       = i_scl;
    raw.sda       = i_sda;
  end

  pin_sync #(
    .W       (5),
    .RST_VAL (PINS_RST)
  ) u_sync (
    .i_clk    (i_clk),
    .i_reset  (i_reset),
    .i_async  (raw),
    .o_stable (pin_s)
  );

  // two-wire gating group
  logic sda_oe_n_r;
  logic sda_oe_n_nxt;
  logic core_scl_r;
  logic core_scl_nxt;
  logic core_sda_r;
  logic core_sda_nxt;
  logic selected;

  always_comb
  begin
    selected     = ~pin_s.select_n;
    // deselected modules see an idle bus so no start is ever decoded
    core_scl_nxt = selected ? pin_s.scl : 1'b1;
    core_sda_nxt = selected ? pin_s.sda : 1'b1;
    sda_oe_n_nxt = ~(selected & i_core_sda_pull);
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      sda_oe_n_r <= 1'b1;
      core_scl_r <= 1'b1;
      core_sda_r <= 1'b1;
    end
    else
    begin
      sda_oe_n_r <= sda_oe_n_nxt;
      core_scl_r <= core_scl_nxt;
      core_sda_r <= core_sda_nxt;
    end
  end

  // reset sequencing group
  rst_state_t       st_r;
  rst_state_t       st_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic             settings_r;
  logic             settings_nxt;
  logic             dnr_r;
  logic             dnr_nxt;
  logic             init_end;

  always_comb
  begin
    st_nxt       = st_r;
    cnt_nxt      = cnt_r;
    settings_nxt = 1'b0;
    dnr_nxt      = dnr_r;
    init_end     = 1'b0;
    unique case (st_r)
      ST_POWERUP, ST_INIT:
      begin
        if (!pin_s.reset_n)
        begin
          // a new low during init restarts pulse qualification
          st_nxt  = ST_RUN;
          cnt_nxt = '0;
        end
        else if (cnt_r == '0)
        begin
          st_nxt   = ST_RUN;
          init_end = 1'b1;
          dnr_nxt  = 1'b0;
        end
        else
        begin
          cnt_nxt = cnt_r - CNT_W'(1);
        end
      end
      ST_RUN:
      begin
        if (pin_s.reset_n)
        begin
          cnt_nxt = '0;
          // a glitch that cut init short runs it again instead of hanging
          if (dnr_r)
          begin
            st_nxt  = ST_INIT;
            cnt_nxt = INIT_LOAD;
          end
        end
        else if (cnt_r == MIN_LAST)
        begin
          st_nxt       = ST_HELD;
          settings_nxt = 1'b1;
          dnr_nxt      = 1'b1;
          cnt_nxt      = '0;
        end
        else
        begin
          cnt_nxt = cnt_r + CNT_W'(1);
        end
      end
      ST_HELD:
      begin
        if (pin_s.reset_n)
        begin
          st_nxt  = ST_INIT;
          cnt_nxt = INIT_LOAD;
        end
      end
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      st_r       <= ST_POWERUP;
      cnt_r      <= PWR_LOAD;
      settings_r <= 1'b0;
      dnr_r      <= 1'b1;
    end
    else
    begin
      st_r       <= st_nxt;
      cnt_r      <= cnt_nxt;
      settings_r <= settings_nxt;
      dnr_r      <= dnr_nxt;
    end
  end

  // status and interrupt group
  logic done_r;
  logic done_nxt;
  logic int_oe_n_r;
  logic int_oe_n_nxt;
  logic lp_r;
  logic lp_nxt;
  logic hold_r;
  logic hold_nxt;

  always_comb
  begin
    // completion event wins over a clear in the same cycle
    done_nxt     = init_end | (done_r & ~i_flags_read);
    // status is meaningless until completion, so nothing is raised before
    int_oe_n_nxt = ~(~dnr_nxt & (done_nxt | i_flag_pending));
    lp_nxt       = pin_s.low_power;
    hold_nxt     = (st_nxt != ST_RUN);
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      done_r     <= 1'b0;
      int_oe_n_r <= 1'b1;
      lp_r       <= 1'b0;
      hold_r     <= 1'b1;
    end
    else
    begin
      done_r     <= done_nxt;
      int_oe_n_r <= int_oe_n_nxt;
      lp_r       <= lp_nxt;
      hold_r     <= hold_nxt;
    end
  end

  // constant-low drive value held in one flip-flop for clean pins
  logic zero_r;

  always_ff @(posedge i_clk)
  begin
    zero_r <= 1'b0;
  end

  assign o_sda_out          = zero_r;
  assign o_sda_oe_n         = sda_oe_n_r;
  assign o_core_scl         = core_scl_r;
  assign o_core_sda         = core_sda_r;
  assign o_present_n        = zero_r;
  assign o_interrupt_n_out  = zero_r;
  assign o_interrupt_n_oe_n = int_oe_n_r;
  assign o_low_power        = lp_r;
  assign o_settings_reset   = settings_r;
  assign o_core_hold        = hold_r;
  assign o_data_not_ready   = dnr_r;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  sequence s_select_idle;
    i_module_select_hiz [*5];
  endsequence

  sequence s_held_release;
    (st_r == ST_HELD) ##1 (st_r == ST_INIT);
  endsequence

  sel_gate_a: assert property (pin_s.select_n |=> o_sda_oe_n)
    else $error("data line driven while deselected");
  sel_pass_a: assert property
    (!pin_s.select_n && i_core_sda_pull |=> !o_sda_oe_n)
    else $error("selected module failed to drive data line");
  sel_pullup_a: assert property
    (s_select_idle |=> o_sda_oe_n && o_core_scl)
    else $error("floating select did not deselect");
  rst_pullup_a: assert property
    (i_module_reset_hiz [*5] |=> !o_settings_reset)
    else $error("floating reset caused a module reset");
  full_reset_a: assert property
    (o_settings_reset |-> o_data_not_ready && st_r == ST_HELD)
    else $error("settings reset outside a held reset");
  rise_start_a: assert property
    (s_held_release |-> $past(pin_s.reset_n) && cnt_r == INIT_LOAD)
    else $error("init interval not started on release");
  done_int_a: assert property
    ($fell(o_data_not_ready) |-> !o_interrupt_n_oe_n && done_r)
    else $error("completion interrupt missing");
  pwr_init_a: assert property
    ($fell(i_reset) |-> o_data_not_ready && st_r == ST_POWERUP)
    else $error("power-up init not pending");
  open_drain_a: assert property (!o_interrupt_n_out && !o_sda_out)
    else $error("pin driven high");
  short_pulse_a: assert property
    (o_settings_reset |-> $past(cnt_r) == MIN_LAST)
    else $error("reset taken before minimum pulse length");
  low_power_a: assert property
    (o_low_power == $past(pin_s.low_power))
    else $error("low power state does not follow request");
  int_mask_a: assert property
    (o_data_not_ready |-> o_interrupt_n_oe_n)
    else $error("interrupt raised while data not ready");
endmodule // module_sideband_control_pins

// *** logic/sideband_pkg.sv ***
// constants and carrier types for the module sideband control pins
package sideband_pkg;
  localparam int unsigned CLK_HZ        = 20_000_000;
  localparam int unsigned CYC_PER_MS    = CLK_HZ / 1000;
  localparam int unsigned CYC_PER_US    = CLK_HZ / 1_000_000;
  // supply-good to fully functional, longest allowed time
  localparam int unsigned POWER_UP_MS   = 2000;
  localparam int unsigned POWER_UP_CYC  = POWER_UP_MS * CYC_PER_MS;
  // initialisation interval after a host reset; plain default
  localparam int unsigned INIT_MS       = 2000;
  localparam int unsigned INIT_CYC      = INIT_MS * CYC_PER_MS;
  // minimum reset pulse length, least time; plain default
  localparam int unsigned MIN_RESET_US  = 10;
  localparam int unsigned MIN_RESET_CYC = MIN_RESET_US * CYC_PER_US;
  localparam int unsigned CNT_W         = 32;
  // idle levels of the synchronised pins after reset
  localparam logic [4:0]  PINS_RST      = 5'h1B;

  typedef struct packed {
    logic select_n;
    logic reset_n;
    logic low_power;
    logic scl;
    logic sda;
  } pins_t;

  typedef enum logic [1:0] {
    ST_POWERUP,
    ST_RUN,
    ST_HELD,
    ST_INIT
  } rst_state_t;
endpackage

// *** logic/pin_sync.sv ***
// three-stage pin synchroniser; output follows once stages two and three agree
`timescale 1ns/10ps
module pin_sync
#(
  parameter int unsigned W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
)
(
  input  wire logic         i_clk,
  input  wire logic         i_reset,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_stable
);
  logic [W-1:0] ff1_r;
  logic [W-1:0] ff2_r;
  logic [W-1:0] ff3_r;
  logic [W-1:0] out_r;
  logic [W-1:0] out_nxt;

  genvar g;
  generate
    for (g = 0; g < W; g++)
    begin : g_bit
      always_comb
      begin
        out_nxt[g] = (ff2_r[g] == ff3_r[g]) ? ff3_r[g] : out_r[g];
      end
    end
  endgenerate

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      ff1_r <= RST_VAL;
      ff2_r <= RST_VAL;
      ff3_r <= RST_VAL;
      out_r <= RST_VAL;
    end
    else
    begin
      ff1_r <= i_async;
      ff2_r <= ff1_r;
      ff3_r <= ff2_r;
      out_r <= out_nxt;
    end
  end

  assign o_stable = out_r;
endmodule // pin_sync

// *** verif/host_model.sv ***
// host-side model: pull-ups on the shared lines and interrupt servicing
`timescale 1ns/10ps
module host_model
(
  input  wire logic i_clk,
  input  wire logic i_reset,
  input  wire logic i_sda_oe_n,
  input  wire logic i_sda_host_n,
  input  wire logic i_int_oe_n,
  output logic      o_sda,
  output logic      o_int_n,
  output logic      o_flags_read
);
  logic [2:0] seen_r;
  // open-drain wires: low if any party pulls, otherwise the pull-up wins
  assign o_sda   = i_sda_oe_n & i_sda_host_n;
  assign o_int_n = i_int_oe_n;
  always @(posedge i_clk)
  begin
    if (i_reset)
      seen_r <= 3'h7;
    else
      seen_r <= {seen_r[1:0], o_int_n};
  end
  // status is only trusted once the interrupt has fallen; one flag read
  assign o_flags_read = (seen_r == 3'h4);
endmodule // host_model

// *** verif/tb_top.sv ***
// self-checking bench for the module sideband control pins
`timescale 1ns/10ps
module tb_top;
  import sideband_pkg::*;
  localparam int PU = 50;
  localparam int IN = 30;
  localparam int MP = 4;
  logic i_clk, i_reset, sel_n, sel_hiz, rst_n, rst_hiz, lp, scl, sda_h_n;
  logic pull, pend, sda, int_n, rd;
  logic sda_out, sda_oe_n, c_scl, c_sda, pres_n, int_out, int_oe_n;
  logic low_pwr, set_rst, hold, dnr;
  int   n_errors, n_checks, n_sr, bad_drive, n;
  // sel_n hiz scl sda_h_n pull lp | oe_n core_scl core_sda low_power
  logic [9:0] rows [5] = '{10'h12E, 10'h09D, 10'h0E4, 10'h27F, 10'h14E};

  module_sideband_control_pins #(.POWER_UP_CYCLES(PU), .INIT_CYCLES(IN),
    .MIN_PULSE_CYCLES(MP)) i_module_sideband_control_pins (
    .i_clk(i_clk), .i_reset(i_reset), .i_module_select_n(sel_n),
    .i_module_select_hiz(sel_hiz), .i_module_reset_n(rst_n),
    .i_module_reset_hiz(rst_hiz), .i_low_power_request(lp), .i_scl(scl),
    .i_sda(sda), .i_core_sda_pull(pull), .i_flag_pending(pend),
    .i_flags_read(rd), .o_sda_out(sda_out), .o_sda_oe_n(sda_oe_n),
    .o_core_scl(c_scl), .o_core_sda(c_sda), .o_present_n(pres_n),
    .o_interrupt_n_out(int_out), .o_interrupt_n_oe_n(int_oe_n),
    .o_low_power(low_pwr), .o_settings_reset(set_rst),
    .o_core_hold(hold), .o_data_not_ready(dnr));

  host_model i_host_model (.i_clk(i_clk), .i_reset(i_reset),
    .i_sda_oe_n(sda_oe_n), .i_sda_host_n(sda_h_n), .i_int_oe_n(int_oe_n),
    .o_sda(sda), .o_int_n(int_n), .o_flags_read(rd));

  initial
  begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end

  // the open-drain outputs may never carry a high level
  always @(posedge i_clk)
  begin
    if (i_reset === 1'b0 && (int_out !== 1'b0 || sda_out !== 1'b0))
      bad_drive++;
    if (set_rst === 1'b1)
      n_sr++;
  end

  task automatic chk(input string nm, input logic e, input logic g);
    n_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("MISMATCH %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge i_clk);
    #1;
  endtask

  task automatic wait_dnr(output int k);
    k = 0;
    while (dnr !== 1'b0 && k < 200)
    begin
      cyc(1);
      k++;
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge i_clk);
    n_errors++;
    tally_and_finish();
  end

  initial
  begin
    {sel_n, sel_hiz, rst_hiz, lp, scl, pull, pend} = '0;
    {i_reset, rst_n, sda_h_n} = 3'h7;
    {n_errors, n_checks, n_sr, bad_drive} = '0;
    cyc(19);
    chk("dnr_in_reset", 1'b1, dnr);
    chk("hold_in_reset", 1'b1, hold);
    chk("int_in_reset", 1'b1, int_n);
    @(posedge i_clk);
    i_reset <= 1'b0;
    wait_dnr(n);
    chk("powerup_time", 1'b1, n >= PU - 2 && n <= PU + 2);
    chk("powerup_int", 1'b0, int_n);
    chk("powerup_hold", 1'b0, hold);
    cyc(8);
    chk("int_cleared", 1'b1, int_n);
    chk("present", 1'b0, pres_n);
    foreach (rows[i])
    begin
      @(posedge i_clk);
      {sel_n, sel_hiz, scl, sda_h_n, pull, lp} <= rows[i][9:4];
      cyc(7);
      chk("sda_oe_n", rows[i][3], sda_oe_n);
      chk("core_scl", rows[i][2], c_scl);
      chk("core_sda", rows[i][1], c_sda);
      chk("low_power", rows[i][0], low_pwr);
    end
    @(posedge i_clk);
    pend <= 1'b1;
    cyc(3);
    chk("flag_int", 1'b0, int_n);
    @(posedge i_clk);
    pend <= 1'b0;
    cyc(3);
    chk("flag_int_off", 1'b1, int_n);
    @(posedge i_clk);
    {rst_n, rst_hiz} <= 2'h1;
    cyc(20);
    @(posedge i_clk);
    rst_n <= 1'b0;
    rst_hiz <= 1'b0;
    repeat (MP - 1) @(posedge i_clk);
    rst_n <= 1'b1;
    cyc(12);
    chk("undriven_short", 1'b1, n_sr == 0);
    chk("short_dnr", 1'b0, dnr);
    @(posedge i_clk);
    rst_n <= 1'b0;
    pend <= 1'b1;
    cyc(12);
    chk("settings_pulse", 1'b1, n_sr == 1);
    chk("held_no_int", 1'b1, int_n);
    cyc(IN + 20);
    chk("held_dnr", 1'b1, dnr);
    chk("held_core", 1'b1, hold);
    @(posedge i_clk);
    rst_n <= 1'b1;
    pend <= 1'b0;
    wait_dnr(n);
    chk("init_from_rise", 1'b1, n >= IN && n <= IN + 8);
    chk("init_int", 1'b0, int_n);
    cyc(8);
    chk("init_int_clr", 1'b1, int_n);
    chk("never_high", 1'b1, bad_drive == 0);
    tally_and_finish();
  end
endmodule // tb_top
